// File: common/fbid_pkg.sv
// fbid_pkg: constants, types and decode helper of the insn decoder
// assumes: hclk is the oscillator; program memory answers in-cycle
//
// Notes on behaviour
// - a 7-bit file address field selects locations 0x00 to 0x7F
// - a 3-bit field selects one bit of the addressed 8-bit register
// - destination bit 0 writes the accumulator, 1 writes the register
// - don't-care bits of a word are ignored whatever their value
// - 0111 add, 0010 reg minus acc, 0101 and, 0100 or, 0110 xor
// - 1101 and 1100 rotate through carry, only carry changes
// - 1011/1111 dec/inc skip on zero, no flags; 0011/1010 only zero
// - top 01: bit clear, set, skip-if-clear, skip-if-set, no flags
// - top 11 literal ops: 1001 and, 1000 or, 1010 xor, 111x add
// - literal minus acc goes to acc, updating carry, digit carry, zero
// - return with literal loads acc, returns, always two cycles
// - low byte 0x63 enters standby, 0x64 clears watchdog, both touch to/pd
// - pc change or true skip costs two cycles, second one a nop
// - writing timer zero clears the prescaler when it is assigned there
// - one insn cycle is four oscillator periods, plain insns take one
// - literal is 8 bits for literal ops, 11 bits for call and jump
package fbid_pkg;
	// ****************
	// timing and sizes
	// ****************
	localparam int OSC_PER_INSN = 4;
	localparam logic [1:0] PHASE_EXEC = 2'(OSC_PER_INSN - 1);
	localparam int STACK_DEPTH = 8;
	localparam int FILE_DEPTH = 128;

	// ****************
	// bus register map
	// ****************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CYC = 8'h08;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PSA = 1;
	localparam int CTRL_WAKE = 2;
	localparam int STAT_FLAGS_POS = 8;
	localparam int STAT_SLEEP_POS = 13;
	localparam int STAT_PC_POS = 16;
	localparam logic [6:0] ADDR_TIMER_ZERO_COUNT = 7'h01;

	// ****************
	// opcode fields
	// ****************
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_BRANCH = 2'h2;
	localparam logic [1:0] CLS_LIT = 2'h3;
	localparam logic [3:0] OPB_MISC = 4'h0;
	localparam logic [3:0] OPB_CLR = 4'h1;
	localparam logic [3:0] OPB_SUB = 4'h2;
	localparam logic [3:0] OPB_DEC = 4'h3;
	localparam logic [3:0] OPB_OR = 4'h4;
	localparam logic [3:0] OPB_AND = 4'h5;
	localparam logic [3:0] OPB_XOR = 4'h6;
	localparam logic [3:0] OPB_ADD = 4'h7;
	localparam logic [3:0] OPB_MOV = 4'h8;
	localparam logic [3:0] OPB_COM = 4'h9;
	localparam logic [3:0] OPB_INC = 4'hA;
	localparam logic [3:0] OPB_DECSZ = 4'hB;
	localparam logic [3:0] OPB_RR = 4'hC;
	localparam logic [3:0] OPB_RL = 4'hD;
	localparam logic [3:0] OPB_SWAP = 4'hE;
	localparam logic [3:0] OPB_INCSZ = 4'hF;
	localparam logic [1:0] BIT_CLR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [3:0] OPL_OR = 4'h8;
	localparam logic [3:0] OPL_AND = 4'h9;
	localparam logic [3:0] OPL_XOR = 4'hA;
	localparam logic [1:0] OPL_MOV2 = 2'h0;
	localparam logic [1:0] OPL_RET2 = 2'h1;
	localparam logic [2:0] OPL_SUB3 = 3'h6;
	localparam logic [2:0] OPL_ADD3 = 3'h7;
	localparam logic [7:0] LOW_RET = 8'h08;
	localparam logic [7:0] LOW_RETI = 8'h09;
	localparam logic [7:0] LOW_SLEEP = 8'h63;
	localparam logic [7:0] LOW_WDT = 8'h64;

	// ****************
	// types
	// ****************
	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RL, ALU_RR,
		ALU_DEC, ALU_INC, ALU_BCLR, ALU_BSET, ALU_PASSA, ALU_PASSB,
		ALU_CLR, ALU_COM, ALU_SWAP
	} fbid_alu_e;

	typedef struct packed {
		logic to;
		logic pd;
		logic z;
		logic dc;
		logic c;
	} fbid_flags_s;

	localparam fbid_flags_s FLAGS_RST = 5'h18;

	typedef struct packed {
		logic [1:0]  cls;
		logic [3:0]  op;
		logic        dest;
		logic [6:0]  faddr;
		logic [2:0]  bsel;
		logic [7:0]  lit8;
		logic [10:0] lit11;
	} fbid_dec_s;

	// split a word into its overlapping operand fields
	function automatic fbid_dec_s fbid_split(input logic [13:0] w);
		fbid_dec_s r;
		r.cls = w[13:12];
		r.op = w[11:8];
		r.dest = w[7];
		r.faddr = w[6:0];
		r.bsel = w[9:7];
		r.lit8 = w[7:0];
		r.lit11 = w[10:0];
		return r;
	endfunction
endpackage

// File: sim/fbid_pm_model.sv
// fbid_pm_model: program memory that feeds the decoder its words
// assumes: bench preloads mem while the core is stopped
module fbid_pm_model
(
	input  wire logic [10:0] pm_addr,
	output logic [13:0]      pm_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [13:0] mem [0:2047];

	// same-cycle read, as the core samples at its execute edge
	assign pm_data = mem[pm_addr];
endmodule

// File: sim/tb.sv
// tb: self-checking bench for fbid_core, bus side and execution
// assumes: fbid_pkg and fbid_pm_model compiled first; 50 MHz hclk
`define CHK(a, e, m) \
	begin \
		n_checks++; \
		if ((a) !== (e)) \
		begin \
			n_fail++; \
			$display("wrong value at %0t: %s", $time, m); \
		end \
	end
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, got_v;
	logic        presc_clear, wdt_clear, standby;
	logic        c, dc, z, d, sk, skip, psa;
	logic [1:0]  htrans;
	logic [2:0]  hsize, b;
	logic [31:0] haddr, hwdata, hrdata, got, pexp;
	logic [31:0] exp_q [$];
	logic [10:0] pm_addr;
	logic [13:0] pm_data;
	logic [7:0]  x, w, r;
	logic [3:0]  op;
	logic [3:0]  ops [16];
	logic [6:0]  f;
	int          n_fail, n_checks, n_cyc, n_presc, n_wdt, i;
	integer      seed = 32'hDD1FB1B0;

	fbid_core uut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pm_addr(pm_addr),
		.pm_data(pm_data), .presc_clear(presc_clear),
		.wdt_clear(wdt_clear), .standby(standby)
	);
	fbid_pm_model pm (.pm_addr(pm_addr), .pm_data(pm_data));

	// ****************
	// clock, monitors
	// ****************
	// free-running oscillator
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// strobe counts, plus a ceiling so a stuck core cannot hang the run
	always @(posedge hclk)
	begin
		n_cyc++;
		if (presc_clear === 1'b1) n_presc++;
		if (wdt_clear === 1'b1) n_wdt++;
		if (n_cyc > 30000)
		begin
			n_fail++;
			test_done();
		end
	end

	// read results against the oldest note
	always @(posedge hclk)
		if (got_v === 1'b1)
		begin
			got_v <= 1'b0;
			`CHK(got, exp_q.pop_front(), "rd")
		end

	// ****************
	// tasks
	// ****************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// reset is re-applied before every program so counts start clean
	task automatic rst();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		n_presc = 0;
		n_wdt = 0;
	endtask

	// one single transfer; read data noted when chk is set
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic chk, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		if (chk)
		begin
			exp_q.push_back(e);
			got <= hrdata;
			got_v <= 1'b1;
		end
	endtask

	// expected status word after the closing standby entry
	function automatic logic [31:0] sw(input logic [10:0] pc,
		input logic [7:0] a);
		return {5'h00, pc, 5'h06, z, dc, c, a};
	endfunction

	// prologue: acc 0 with c, dc, z all set, then acc = x
	task automatic pro();
		pm.mem[0] = {fbid_pkg::CLS_LIT, fbid_pkg::OPL_MOV2,
			2'($random(seed)), 8'hFF};
		pm.mem[1] = {fbid_pkg::CLS_LIT, fbid_pkg::OPL_ADD3,
			1'($random(seed)), 8'h01};
		pm.mem[2] = {fbid_pkg::CLS_LIT, fbid_pkg::OPL_MOV2, 2'h0, x};
		c = 1'b1;
		dc = 1'b1;
		z = 1'b1;
	endtask

	// start, wait for standby, then check state, cycles and prescaler clear count
	task automatic run(input logic [31:0] st, input logic [31:0] cy);
		bus(1'b1, fbid_pkg::REG_CTRL, {30'h0, psa, 1'b1}, 1'b0, 0);
		do bus(1'b0, fbid_pkg::REG_STAT, 0, 1'b0, 0);
		while (hrdata[fbid_pkg::STAT_SLEEP_POS] !== 1'b1);
		bus(1'b0, fbid_pkg::REG_STAT, 0, 1'b1, st);
		bus(1'b0, fbid_pkg::REG_CYC, 0, 1'b1, cy);
		`CHK(standby, 1'b1, "standby")
		`CHK(32'(n_presc), pexp, "prescaler clear")
	endtask

	// ****************
	// main sequence
	// ****************
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		got_v = 1'b0;
		ops = '{fbid_pkg::OPB_ADD, fbid_pkg::OPB_SUB, fbid_pkg::OPB_AND,
			fbid_pkg::OPB_OR, fbid_pkg::OPB_XOR, fbid_pkg::OPB_RL,
			fbid_pkg::OPB_RR, fbid_pkg::OPB_DEC, fbid_pkg::OPB_INC,
			fbid_pkg::OPB_DECSZ, fbid_pkg::OPB_INCSZ, fbid_pkg::OPL_AND,
			fbid_pkg::OPL_OR, fbid_pkg::OPL_XOR,
			{fbid_pkg::OPL_ADD3, 1'b0}, {fbid_pkg::OPL_SUB3, 1'b0}};
		// register map: reset values, unmapped and read-only places
		rst();
		bus(1'b0, fbid_pkg::REG_STAT, 0, 1'b1, 32'h00001800);
		bus(1'b0, 8'h0C, 0, 1'b1, 32'h0);
		bus(1'b1, fbid_pkg::REG_STAT, 32'hFFFFFFFF, 1'b0, 0);
		bus(1'b0, fbid_pkg::REG_STAT, 0, 1'b1, 32'h00001800);
		bus(1'b1, fbid_pkg::REG_CTRL, 32'h2, 1'b0, 0);
		bus(1'b0, fbid_pkg::REG_CTRL, 0, 1'b1, 32'h2);
		$display("test registers done");
		// literal operations, both values of the don't-care bit
		for (i = 0; i < 10; i++)
		begin
			rst();
			x = 8'($random(seed));
			w = 8'($random(seed));
			psa = 1'($random(seed));
			pexp = 0;
			pro();
			op = ops[11 + i % 5] ^ 4'(i % 5 > 2 ? i / 5 : 0);
			case (i % 5)
				0: r = x & w;
				1: r = x | w;
				2: r = x ^ w;
				3: {c, r} = x + w;
				default: r = w - x;
			endcase
			if (i % 5 == 3) dc = 5'(x[3:0]) + 5'(w[3:0]) > 5'h0F;
			if (i % 5 == 4) c = w >= x;
			if (i % 5 == 4) dc = w[3:0] >= x[3:0];
			z = r == 8'h00;
			pm.mem[3] = {fbid_pkg::CLS_LIT, op, w};
			pm.mem[4] = {6'h00, fbid_pkg::LOW_SLEEP};
			run(sw(11'h005, r), 32'h5);
		end
		$display("test literal done");
		// byte operations; first round forces every skip to be taken
		for (i = 0; i < 22; i++)
		begin
			rst();
			op = ops[i % 11];
			sk = op == fbid_pkg::OPB_DECSZ || op == fbid_pkg::OPB_INCSZ;
			x = 8'($random(seed));
			w = 8'($random(seed));
			if (i < 11 && sk) x = op == fbid_pkg::OPB_DECSZ ? 8'h01 : 8'hFF;
			d = sk ? 1'b0 : 1'($random(seed));
			f = i == 0 ? 7'h7F : 7'h40 | 7'($random(seed));
			psa = 1'($random(seed));
			pexp = 0;
			pro();
			case (op)
				fbid_pkg::OPB_ADD: {c, r} = x + w;
				fbid_pkg::OPB_SUB: r = x - w;
				fbid_pkg::OPB_AND: r = x & w;
				fbid_pkg::OPB_OR: r = x | w;
				fbid_pkg::OPB_XOR: r = x ^ w;
				fbid_pkg::OPB_RL: {c, r} = {x, 1'b1};
				fbid_pkg::OPB_RR: {r, c} = {1'b1, x};
				fbid_pkg::OPB_DEC, fbid_pkg::OPB_DECSZ: r = x - 8'h01;
				default: r = x + 8'h01;
			endcase
			if (op == fbid_pkg::OPB_ADD) dc = 5'(x[3:0]) + 5'(w[3:0]) > 5'h0F;
			if (op == fbid_pkg::OPB_SUB) c = x >= w;
			if (op == fbid_pkg::OPB_SUB) dc = x[3:0] >= w[3:0];
			if (!sk && op[3:1] != 3'h6) z = r == 8'h00;
			skip = sk && r == 8'h00;
			if (sk && !skip) r = ~r;
			if ((sk && !skip) || d) z = r == 8'h00;
			pm.mem[3] = {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_MISC, 1'b1, f};
			pm.mem[4] = {fbid_pkg::CLS_LIT, fbid_pkg::OPL_MOV2, 2'h0, w};
			pm.mem[5] = {fbid_pkg::CLS_BYTE, op, d, f};
			pm.mem[6] = sk ? {fbid_pkg::CLS_LIT, fbid_pkg::OPL_XOR, 8'hFF}
				: 14'h0000;
			pm.mem[7] = d ? {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_MOV, 1'b0, f}
				: 14'h0000;
			pm.mem[8] = {6'h00, fbid_pkg::LOW_SLEEP};
			run(sw(11'h009, r), 32'h9);
		end
		$display("test byte done");
		// bit operations over all eight bit positions, timer zero write
		for (i = 0; i < 8; i++)
		begin
			rst();
			op = 4'(i % 4);
			b = 3'(i * 3);
			x = 8'($random(seed));
			if (x == 8'h00) x = 8'h5A;
			f = 7'h40 | 7'($random(seed));
			psa = 1'($random(seed));
			pexp = 32'(psa);
			pro();
			r = x;
			r[b] = op[0];
			skip = x[b] == op[0];
			if (op[1]) r = skip ? x : 8'h00;
			z = op[1] ? 1'b1 : r == 8'h00;
			pm.mem[3] = {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_MISC, 1'b1, f};
			pm.mem[4] = {fbid_pkg::CLS_BIT, op[1:0], b, f};
			pm.mem[5] = op[1] ? {fbid_pkg::CLS_LIT, fbid_pkg::OPL_AND, 8'h00}
				: 14'h0000;
			pm.mem[6] = op[1] ? 14'h0000
				: {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_MOV, 1'b0, f};
			pm.mem[7] = {fbid_pkg::CLS_BIT, fbid_pkg::BIT_SET, b,
				fbid_pkg::ADDR_TIMER_ZERO_COUNT};
			pm.mem[8] = {6'h00, fbid_pkg::LOW_SLEEP};
			run(sw(11'h009, r), 32'h9);
		end
		$display("test bit done");
		// call, return with literal, far jump, watchdog clear, wake
		rst();
		x = 8'($random(seed));
		psa = 1'b1;
		pexp = 0;
		c = 1'b0;
		dc = 1'b0;
		r = ~{x[3:0], x[7:4]};
		z = r == 8'h00;
		// return_with_literal loads acc, the plain return after it must not touch it
		pm.mem[0] = {fbid_pkg::CLS_BRANCH, 1'b0, 11'h003};
		pm.mem[1] = {fbid_pkg::CLS_BRANCH, 1'b0, 11'h004};
		pm.mem[2] = {fbid_pkg::CLS_BRANCH, 1'b1, 11'h7F0};
		pm.mem[3] = {fbid_pkg::CLS_LIT, fbid_pkg::OPL_RET2, 2'h2, x};
		pm.mem[4] = {6'h00, fbid_pkg::LOW_RET};
		pm.mem[11'h7F0] = {6'h00, fbid_pkg::LOW_WDT};
		// store acc, swap nibbles in place, complement into acc
		pm.mem[11'h7F1] = {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_MISC, 1'b1,
			7'h40};
		pm.mem[11'h7F2] = {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_SWAP, 1'b1,
			7'h40};
		pm.mem[11'h7F3] = {fbid_pkg::CLS_BYTE, fbid_pkg::OPB_COM, 1'b0,
			7'h40};
		pm.mem[11'h7F4] = {6'h00, fbid_pkg::LOW_SLEEP};
		run(sw(11'h7F5, r), 32'hF);
		`CHK(32'(n_wdt), 32'h1, "watchdog clear")
		bus(1'b1, fbid_pkg::REG_CTRL, 32'h4, 1'b0, 0);
		bus(1'b0, fbid_pkg::REG_CTRL, 0, 1'b1, 32'h0);
		`CHK(standby, 1'b0, "wake")
		$display("test branch done");
		repeat (4) @(posedge hclk);
		test_done();
	end
endmodule

// File: verilog/fbid_alu.sv
// fbid_alu: 8-bit datapath for one decoded operation
// assumes: caller picks operand and decides which flags to keep
module fbid_alu
(
	input  wire logic [7:0]          acc,
	input  wire logic [7:0]          opnd,
	input  wire logic                cin,
	input  wire logic [2:0]          bsel,
	input  wire fbid_pkg::fbid_alu_e op,
	output logic [7:0]               res,
	output logic                     cout,
	output logic                     dcout
);
	logic [8:0] sum;
	logic [4:0] nib;

	// subtract is opnd minus acc; carry high means no borrow
	always_comb
	begin
		sum = {1'b0, opnd} + {1'b0, acc};
		nib = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
		if (op == fbid_pkg::ALU_SUB)
		begin
			sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
			nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		end
		cout = sum[8];
		dcout = nib[4];
		unique case (op)
			fbid_pkg::ALU_ADD, fbid_pkg::ALU_SUB: res = sum[7:0];
			fbid_pkg::ALU_AND: res = acc & opnd;
			fbid_pkg::ALU_OR: res = acc | opnd;
			fbid_pkg::ALU_XOR: res = acc ^ opnd;
			fbid_pkg::ALU_RL:
			begin
				res = {opnd[6:0], cin};
				cout = opnd[7];
			end
			fbid_pkg::ALU_RR:
			begin
				res = {cin, opnd[7:1]};
				cout = opnd[0];
			end
			fbid_pkg::ALU_DEC: res = opnd - 8'h01;
			fbid_pkg::ALU_INC: res = opnd + 8'h01;
			fbid_pkg::ALU_BCLR: res = opnd & ~(8'h01 << bsel);
			fbid_pkg::ALU_BSET: res = opnd | (8'h01 << bsel);
			fbid_pkg::ALU_PASSA: res = acc;
			fbid_pkg::ALU_PASSB: res = opnd;
			fbid_pkg::ALU_CLR: res = 8'h00;
			fbid_pkg::ALU_COM: res = ~opnd;
			fbid_pkg::ALU_SWAP: res = {opnd[3:0], opnd[7:4]};
		endcase
	end
endmodule

// File: verilog/fbid_core.sv
// fbid_core: decode and execution of 14-bit words, with AHB-Lite regs
// assumes: pm_data is combinational from pm_addr on the same clock
module fbid_core
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic [10:0]      pm_addr,
	input  wire logic [13:0] pm_data,
	output logic             presc_clear,
	output logic             wdt_clear,
	output logic             standby
);
	// ****************
	// declarations
	// ****************
	logic                  run;
	logic                  psa;
	logic                  wake;
	logic                  wr_pend;
	logic [7:0]            wr_addr;
	logic                  sel_ok;
	logic [31:0]           rd_val;
	logic [31:0]           cycles;
	logic [1:0]            phase;
	logic                  ex;
	logic                  take;
	logic                  flush;
	logic [10:0]           pc;
	logic [2:0]            sp;
	logic [10:0]           stack [fbid_pkg::STACK_DEPTH];
	logic [7:0]            fmem [fbid_pkg::FILE_DEPTH];
	logic [7:0]            acc;
	fbid_pkg::fbid_flags_s flags;
	fbid_pkg::fbid_dec_s   d;
	fbid_pkg::fbid_alu_e   alu_op;
	logic [7:0]            opnd;
	logic [7:0]            alu_res;
	logic                  alu_c;
	logic                  alu_dc;
	logic                  to_f;
	logic                  to_a;
	logic                  upd_c;
	logic                  upd_dc;
	logic                  upd_z;
	logic                  skipz;
	logic                  skipb;
	logic                  skip_now;
	logic                  jump;
	logic                  call;
	logic                  ret;
	logic                  nap;
	logic                  wdt;

	// ****************
	// bus slave
	// ****************
	// zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign sel_ok = hsel && htrans[1] && hready;

	// address phase of a write is held for its data phase
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= sel_ok && hwrite && haddr[31:8] == 24'h000000;
			wr_addr <= haddr[7:0];
		end

	// control: run gate, prescaler assignment, wake strobe
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			run <= 1'b0;
			psa <= 1'b0;
			wake <= 1'b0;
		end
		else
		begin
			wake <= wr_pend && wr_addr == fbid_pkg::REG_CTRL
				&& hwdata[fbid_pkg::CTRL_WAKE];
			if (wr_pend && wr_addr == fbid_pkg::REG_CTRL)
			begin
				run <= hwdata[fbid_pkg::CTRL_RUN];
				psa <= hwdata[fbid_pkg::CTRL_PSA];
			end
		end

	// read mux; unmapped words read as zero
	always_comb
	begin
		rd_val = 32'h00000000;
		if (haddr[31:8] == 24'h000000)
			unique case (haddr[7:0])
				fbid_pkg::REG_CTRL: rd_val = {30'h00000000, psa, run};
				fbid_pkg::REG_STAT:
				begin
					rd_val[7:0] = acc;
					rd_val[fbid_pkg::STAT_FLAGS_POS +: 5] = flags;
					rd_val[fbid_pkg::STAT_SLEEP_POS] = standby;
					rd_val[fbid_pkg::STAT_PC_POS +: 11] = pc;
				end
				fbid_pkg::REG_CYC: rd_val = cycles;
				default: rd_val = 32'h00000000;
			endcase
	end

	// read data captured at the address phase, stands in the data phase
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (sel_ok && !hwrite)
			hrdata <= rd_val;

	// ****************
	// cycle timing
	// ****************
	// free-running quarter counter; one execute slot per four periods
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;

	assign ex = phase == fbid_pkg::PHASE_EXEC && run && !standby;
	assign take = ex && !flush;

	// executed insn cycles, nops included
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cycles <= 32'h00000000;
		else if (ex)
			cycles <= cycles + 32'h00000001;

	// ****************
	// decode
	// ****************
	assign pm_addr = pc;
	assign d = fbid_pkg::fbid_split(pm_data);

	// op select, destination and flag mask per class
	always_comb
	begin
		alu_op = fbid_pkg::ALU_PASSB;
		opnd = fmem[d.faddr];
		to_f = 1'b0;
		to_a = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		skipz = 1'b0;
		skipb = 1'b0;
		jump = 1'b0;
		call = 1'b0;
		ret = 1'b0;
		nap = 1'b0;
		wdt = 1'b0;
		unique case (d.cls)
			fbid_pkg::CLS_BYTE:
			begin
				to_f = d.dest;
				to_a = !d.dest;
				upd_z = 1'b1;
				unique case (d.op)
					fbid_pkg::OPB_MISC:
					begin
						alu_op = fbid_pkg::ALU_PASSA;
						to_a = 1'b0;
						upd_z = 1'b0;
						if (!d.dest)
						begin
							// any other pattern here is a nop
							nap = d.lit8 == fbid_pkg::LOW_SLEEP;
							wdt = d.lit8 == fbid_pkg::LOW_WDT;
							ret = d.lit8 == fbid_pkg::LOW_RET
								|| d.lit8 == fbid_pkg::LOW_RETI;
						end
					end
					// clear acc ignores the low seven bits
					fbid_pkg::OPB_CLR: alu_op = fbid_pkg::ALU_CLR;
					fbid_pkg::OPB_SUB:
					begin
						alu_op = fbid_pkg::ALU_SUB;
						upd_c = 1'b1;
						upd_dc = 1'b1;
					end
					fbid_pkg::OPB_ADD:
					begin
						alu_op = fbid_pkg::ALU_ADD;
						upd_c = 1'b1;
						upd_dc = 1'b1;
					end
					fbid_pkg::OPB_AND: alu_op = fbid_pkg::ALU_AND;
					fbid_pkg::OPB_OR: alu_op = fbid_pkg::ALU_OR;
					fbid_pkg::OPB_XOR: alu_op = fbid_pkg::ALU_XOR;
					fbid_pkg::OPB_DEC: alu_op = fbid_pkg::ALU_DEC;
					fbid_pkg::OPB_INC: alu_op = fbid_pkg::ALU_INC;
					fbid_pkg::OPB_MOV: alu_op = fbid_pkg::ALU_PASSB;
					fbid_pkg::OPB_COM: alu_op = fbid_pkg::ALU_COM;
					fbid_pkg::OPB_DECSZ, fbid_pkg::OPB_INCSZ:
					begin
						alu_op = d.op[2] ? fbid_pkg::ALU_INC
							: fbid_pkg::ALU_DEC;
						upd_z = 1'b0;
						skipz = 1'b1;
					end
					fbid_pkg::OPB_RL, fbid_pkg::OPB_RR:
					begin
						alu_op = d.op[0] ? fbid_pkg::ALU_RL
							: fbid_pkg::ALU_RR;
						upd_z = 1'b0;
						upd_c = 1'b1;
					end
					fbid_pkg::OPB_SWAP:
					begin
						alu_op = fbid_pkg::ALU_SWAP;
						upd_z = 1'b0;
					end
				endcase
			end
			fbid_pkg::CLS_BIT:
			begin
				// no flag touched by any bit op
				alu_op = d.op[2] ? fbid_pkg::ALU_BSET : fbid_pkg::ALU_BCLR;
				to_f = d.op[3:2] == fbid_pkg::BIT_CLR
					|| d.op[3:2] == fbid_pkg::BIT_SET;
				skipb = d.op[3] && opnd[d.bsel] == d.op[2];
			end
			fbid_pkg::CLS_BRANCH:
			begin
				jump = d.op[3];
				call = !d.op[3];
			end
			fbid_pkg::CLS_LIT:
			begin
				opnd = d.lit8;
				to_a = 1'b1;
				upd_z = 1'b1;
				if (d.op[3:2] == fbid_pkg::OPL_MOV2)
					upd_z = 1'b0; // low bits ignored
				else if (d.op[3:2] == fbid_pkg::OPL_RET2)
				begin
					upd_z = 1'b0;
					ret = 1'b1;
				end
				else if (d.op[3:1] == fbid_pkg::OPL_SUB3
					|| d.op[3:1] == fbid_pkg::OPL_ADD3)
				begin
					alu_op = d.op[1] ? fbid_pkg::ALU_ADD
						: fbid_pkg::ALU_SUB;
					upd_c = 1'b1;
					upd_dc = 1'b1;
				end
				else if (d.op == fbid_pkg::OPL_AND)
					alu_op = fbid_pkg::ALU_AND;
				else if (d.op == fbid_pkg::OPL_OR)
					alu_op = fbid_pkg::ALU_OR;
				else if (d.op == fbid_pkg::OPL_XOR)
					alu_op = fbid_pkg::ALU_XOR;
				else
				begin
					// undefined literal pattern does nothing
					to_a = 1'b0;
					upd_z = 1'b0;
				end
			end
		endcase
	end

	fbid_alu u_alu
	(
		.acc   (acc),
		.opnd  (opnd),
		.cin   (flags.c),
		.bsel  (d.bsel),
		.op    (alu_op),
		.res   (alu_res),
		.cout  (alu_c),
		.dcout (alu_dc)
	);

	assign skip_now = (skipz && alu_res == 8'h00) || skipb;

	// ****************
	// execute
	// ****************
	// pc and nop slot; the nop holds pc so the next word is refetched
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			pc <= 11'h000;
			sp <= 3'h0;
			flush <= 1'b0;
		end
		else if (ex)
		begin
			flush <= !flush && (jump || call || ret || skip_now);
			if (!flush)
			begin
				if (jump || call)
					pc <= d.lit11;
				else if (ret)
					pc <= stack[sp - 3'h1];
				else if (skip_now)
					pc <= pc + 11'h002;
				else
					pc <= pc + 11'h001;
				if (call)
					sp <= sp + 3'h1;
				else if (ret)
					sp <= sp - 3'h1;
			end
		end

	// return stack wraps silently on overflow, like a ring
	always_ff @(posedge hclk)
		if (take && call)
			stack[sp] <= pc + 11'h001;

	// file registers, result written back when destination says so
	always_ff @(posedge hclk)
		if (take && to_f)
			fmem[d.faddr] <= alu_res;

	// accumulator; a plain return must leave it alone, so only to_a loads
	// it and return with literal passes its literal through the alu
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			acc <= 8'h00;
		else if (take && to_a)
			acc <= alu_res;

	// status flags under the per-op mask
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			flags <= fbid_pkg::FLAGS_RST;
		else if (take)
		begin
			if (upd_c)
				flags.c <= alu_c;
			if (upd_dc)
				flags.dc <= alu_dc;
			if (upd_z)
				flags.z <= alu_res == 8'h00;
			if (nap || wdt)
			begin
				flags.to <= 1'b1;
				flags.pd <= wdt;
			end
		end

	// standby: entered by the sleep word, left by a wake write
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			standby <= 1'b0;
		else if (take && nap)
			standby <= 1'b1;
		else if (wake)
			standby <= 1'b0;

	// one-cycle strobes to the timer and watchdog blocks
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			presc_clear <= 1'b0;
			wdt_clear <= 1'b0;
		end
		else
		begin
			presc_clear <= take && to_f && psa
				&& d.faddr == fbid_pkg::ADDR_TIMER_ZERO_COUNT;
			wdt_clear <= take && wdt;
		end

	// ****************
	// assertions
	// ****************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cycle;
		ex |=> !ex [*3];
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("execute slots closer than four periods");

	property p_dest;
		take && d.cls == fbid_pkg::CLS_BYTE && !d.dest
			&& d.op != fbid_pkg::OPB_MISC |=> acc == $past(alu_res);
	endproperty
	a_dest: assert property (p_dest)
		else $error("byte op with d=0 did not load acc");

	property p_add;
		take && d.cls == fbid_pkg::CLS_BYTE && d.op == fbid_pkg::OPB_ADD
			|=> flags.c == $past(alu_c) && flags.dc == $past(alu_dc);
	endproperty
	a_add: assert property (p_add)
		else $error("add did not update carry flags");

	property p_rot;
		take && d.cls == fbid_pkg::CLS_BYTE && d.op[3:1] == 3'h6
			|=> $stable(flags.z) && flags.c == $past(alu_c);
	endproperty
	a_rot: assert property (p_rot)
		else $error("rotate flag update wrong");

	property p_skipz;
		take && skipz |=> $stable(flags)
			&& flush == ($past(alu_res) == 8'h00);
	endproperty
	a_skipz: assert property (p_skipz)
		else $error("skip on zero wrong");

	property p_bitop;
		take && d.cls == fbid_pkg::CLS_BIT |=> $stable(flags);
	endproperty
	a_bitop: assert property (p_bitop)
		else $error("bit op changed flags");

	property p_land;
		take && d.cls == fbid_pkg::CLS_LIT && d.op == fbid_pkg::OPL_AND
			|=> acc == ($past(acc) & $past(d.lit8));
	endproperty
	a_land: assert property (p_land)
		else $error("literal and result wrong");

	property p_lsub;
		take && d.cls == fbid_pkg::CLS_LIT
			&& d.op[3:1] == fbid_pkg::OPL_SUB3
			|=> acc == 8'($past(d.lit8) - $past(acc));
	endproperty
	a_lsub: assert property (p_lsub)
		else $error("literal minus acc wrong");

	property p_return_with_literal;
		take && d.cls == fbid_pkg::CLS_LIT
			&& d.op[3:2] == fbid_pkg::OPL_RET2
			|=> acc == $past(d.lit8) && flush;
	endproperty
	a_return_with_literal: assert property (p_return_with_literal)
		else $error("return with literal wrong");

	property p_nap;
		take && nap |=> standby && !flags.pd && flags.to;
	endproperty
	a_nap: assert property (p_nap)
		else $error("standby entry wrong");

	property p_nop;
		ex && flush |=> $stable(acc) && $stable(pc) && !flush;
	endproperty
	a_nop: assert property (p_nop)
		else $error("second cycle was not a nop");

	property p_timer_zero_count;
		take && to_f && psa && d.faddr == fbid_pkg::ADDR_TIMER_ZERO_COUNT
			|=> presc_clear ##1 !presc_clear;
	endproperty
	a_timer_zero_count: assert property (p_timer_zero_count)
		else $error("prescaler clear missing");

	property p_jump;
		take && d.cls == fbid_pkg::CLS_BRANCH
			|=> pc == $past(d.lit11) && flush;
	endproperty
	a_jump: assert property (p_jump)
		else $error("jump or call target wrong");

	c_skip: cover property (take && skip_now);
	c_call: cover property (take && call ##8 take && ret);
	c_nap: cover property (take && nap);
endmodule
